// ==== hw/hcl_pkg.sv ====
// shared constants and types of the command list handler
package hcl_pkg;
  // ==========================================================
  // request block layout, word offsets inside the 64-word block
  localparam int             BLK_WORDS = 64;
  localparam logic [5:0]     W_SEQ     = 6'h00;
  localparam logic [5:0]     W_ID      = 6'h01;
  localparam logic [5:0]     W_CHAN    = 6'h02;
  localparam logic [5:0]     W_CNT     = 6'h03;
  localparam logic [5:0]     W_LIST    = 6'h04;
  // ==========================================================
  // block identifiers and enable word values
  localparam logic [15:0]    ID_ENABLE  = 16'h26ae;
  localparam logic [15:0]    ID_DISABLE = 16'h26af;
  localparam logic [15:0]    ID_WARM    = 16'h270e;
  localparam logic [15:0]    ID_COLD    = 16'h270f;
  localparam logic [15:0]    EN_ON      = 16'hffff;
  localparam logic [15:0]    EN_OFF     = 16'h0000;
  localparam logic [15:0]    MAX_CNT    = 16'h003c;
  localparam logic [15:0]    MIN_CNT    = 16'h0001;
  // ==========================================================
  // channels and command lists
  localparam int             NCH        = 2;
  localparam logic [15:0]    NCH_W      = 16'h0002;
  localparam int             LIST_LEN   = 99;
  localparam logic [6:0]     LIST_LEN_W = 7'h63;
  localparam logic [2:0]     CODE_OFF   = 3'h0;
  localparam logic [2:0]     CODE_CONT  = 3'h4;
  localparam logic [2:0]     CODE_ONCE  = 3'h5;
  localparam logic [3:0]     ADDR_P2P   = 4'h0;
  localparam logic [3:0]     ADDR_MD_LO = 4'h1;
  localparam logic [3:0]     ADDR_MD_HI = 4'hf;
  localparam logic [7:0]     CMD_ID     = 8'h00;
  // ==========================================================
  // controller registers on the AXI4-Lite slave, byte offsets
  localparam logic [7:0]     REG_SEND   = 8'h00;
  localparam logic [7:0]     REG_CHAN   = 8'h04;
  localparam logic [7:0]     REG_CNT    = 8'h08;
  localparam logic [7:0]     REG_STAT   = 8'h0c;
  localparam logic [7:0]     REG_LIST   = 8'h10;
  localparam logic [1:0]     RESP_OKAY  = 2'h0;
  localparam logic [1:0]     RESP_SLV   = 2'h2;
  // ==========================================================
  // types
  typedef logic [15:0] hcl_word_t;
  typedef hcl_word_t [BLK_WORDS-1:0] hcl_blk_t;
  typedef enum logic [1:0] {POLL_NONE, POLL_P2P, POLL_MULTI} hcl_poll_t;
endpackage : hcl_pkg

// ==== hw/hcl_if.sv ====
// request block exchange between controller and handler
`timescale 1ns/1ps
interface hcl_if;
  import hcl_pkg::*;
  hcl_blk_t blk;      // request block, held by the controller
  logic     blk_clr;  // handler asks for a zeroed block
  modport dev  (input blk, output blk_clr);
  modport host (output blk, input blk_clr);
endinterface : hcl_if

// ==== hw/hcl_dev.sv ====
// command list handler: request decoder and two channel schedulers
// Function
// - act only when sequence word changes
// - enable request sets gated enable words
// - one-shot command clears enable after running
// - disable request zeroes gated enable words
// - word two selects the target channel
// - controller keeps count within one to sixty
// - indices come from words four onward
// - no reply to enable or disable
// - restart request zeroes block then restarts
// - one identifier warm, other cold restart
// - two independent master channels
// - three poll modes, list always runs
// - point-to-point polls short address zero
// - multi-drop polls addresses one to fifteen
// - no-poll mode runs enabled list only
// - up to 99 list entries per channel
// - entry picks database or constant data
// - long addressing queries long address first
// - second master option slows the timing
// - first sixty-four words are control block
// - unknown identifier does nothing
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hcl_dev (
  input  logic                                    CLK,
  input  logic                                    RST_B,
  hcl_if.dev                                      LNK,
  input  hcl_pkg::hcl_poll_t [hcl_pkg::NCH-1:0]   POLL_MODE,
  input  logic [hcl_pkg::NCH-1:0]                 SECOND_MASTER,
  input  logic [hcl_pkg::NCH-1:0][6:0]            LIST_LEN_CFG,
  input  logic [hcl_pkg::NCH-1:0][98:0][2:0]      ENTRY_CODE,
  input  logic [hcl_pkg::NCH-1:0][98:0][3:0]      ENTRY_ADDR,
  input  logic [hcl_pkg::NCH-1:0][98:0][7:0]      ENTRY_CMD,
  input  logic [hcl_pkg::NCH-1:0][98:0]           ENTRY_LONG,
  input  logic [hcl_pkg::NCH-1:0][98:0]           ENTRY_CONST,
  input  logic [hcl_pkg::NCH-1:0]                 TX_DONE,
  output logic [hcl_pkg::NCH-1:0]                 TX_VALID,
  output logic [hcl_pkg::NCH-1:0][3:0]            TX_ADDR,
  output logic [hcl_pkg::NCH-1:0][7:0]            TX_CMD,
  output logic [hcl_pkg::NCH-1:0][6:0]            TX_ENTRY,
  output logic [hcl_pkg::NCH-1:0]                 TX_LONG,
  output logic [hcl_pkg::NCH-1:0]                 TX_CONST,
  output logic [hcl_pkg::NCH-1:0]                 TX_AUTO,
  output logic [hcl_pkg::NCH-1:0]                 TX_FAST,
  output logic [hcl_pkg::NCH-1:0][98:0][15:0]     EN_WORDS,
  output logic                                    RESTART_WARM,
  output logic                                    RESTART_COLD
);
  import hcl_pkg::*;

  // ==========================================================
  // state types
  typedef enum logic [1:0] {R_IDLE, R_WALK, R_BOOT} hcl_req_t;
  typedef enum logic [1:0] {C_PICK, C_LQ, C_WAIT} hcl_chs_t;

  typedef struct packed {
    hcl_req_t                             rst;
    hcl_word_t                            seen;
    hcl_word_t                            id;
    logic                                 ch;
    logic [5:0]                           k;
    logic [5:0]                           cnt;
    logic                                 clr;
    logic                                 warm;
    logic                                 cold;
    logic [NCH-1:0][LIST_LEN-1:0][15:0]   en;
    hcl_chs_t [NCH-1:0]                   cst;
    logic [NCH-1:0][6:0]                  ent;
    logic [NCH-1:0][3:0]                  sa;
    logic [NCH-1:0]                       turn;
    logic [NCH-1:0]                       tv;
    logic [NCH-1:0]                       tl;
    logic [NCH-1:0]                       tc;
    logic [NCH-1:0]                       ta;
    logic [NCH-1:0]                       tf;
    logic [NCH-1:0][3:0]                  tadr;
    logic [NCH-1:0][7:0]                  tcmd;
  } hcl_dst_t;

  hcl_dst_t  s_q;
  hcl_dst_t  s_d;
  hcl_word_t wi;
  hcl_word_t cw;

  // ==========================================================
  // decoders for the schedulers; gated is also used by the request walk
  function automatic logic gated(input logic [2:0] code);
    gated = (code == CODE_CONT) || (code == CODE_ONCE);
  endfunction : gated

  function automatic logic [6:0] nxt(input logic [6:0] e,
                                     input logic [6:0] len);
    if (e + 7'h01 >= len || e + 7'h01 >= LIST_LEN_W) nxt = 7'h00;
    else nxt = e + 7'h01;
  endfunction : nxt

  function automatic logic [3:0] md(input logic [3:0] a);
    md = (a == ADDR_P2P) ? ADDR_MD_LO : a;
  endfunction : md

  // current index word and raw count word
  assign wi = LNK.blk[W_LIST + s_q.k];
  assign cw = LNK.blk[W_CNT];

  // ==========================================================
  // next-state logic
  always_comb begin
    s_d      = s_q;
    s_d.clr  = 1'b0;
    s_d.warm = 1'b0;
    s_d.cold = 1'b0;
    s_d.tf   = ~SECOND_MASTER;

    // each channel runs its own scheduler, no shared state
    for (int c = 0; c < NCH; c++) begin
      case (s_q.cst[c])
        C_PICK: begin
          if (s_q.turn[c] && POLL_MODE[c] != POLL_NONE) begin
            s_d.turn[c] = 1'b0;
            s_d.tv[c]   = 1'b1;
            s_d.ta[c]   = 1'b1;
            s_d.tl[c]   = 1'b0;
            s_d.tc[c]   = 1'b0;
            s_d.tcmd[c] = CMD_ID;
            s_d.cst[c]  = C_WAIT;
            if (POLL_MODE[c] == POLL_P2P) begin
              s_d.tadr[c] = ADDR_P2P;
              s_d.sa[c]   = ADDR_P2P;
            end else begin
              s_d.tadr[c] = md(s_q.sa[c]);
              s_d.sa[c]   = (md(s_q.sa[c]) == ADDR_MD_HI) ?
                            ADDR_MD_LO : md(s_q.sa[c]) + 4'h1;
            end
          end else if (s_q.ent[c] < LIST_LEN_CFG[c] &&
                       (gated(ENTRY_CODE[c][s_q.ent[c]]) ?
                        s_q.en[c][s_q.ent[c]] != EN_OFF :
                        ENTRY_CODE[c][s_q.ent[c]] != CODE_OFF)) begin
            // enabled user entry; in none mode only this branch sends
            s_d.tv[c]   = 1'b1;
            s_d.ta[c]   = 1'b0;
            s_d.tl[c]   = 1'b0;
            s_d.tc[c]   = ENTRY_CONST[c][s_q.ent[c]];
            s_d.tadr[c] = ENTRY_ADDR[c][s_q.ent[c]];
            if (ENTRY_LONG[c][s_q.ent[c]]) begin
              s_d.tcmd[c] = CMD_ID;
              s_d.cst[c]  = C_LQ;
            end else begin
              s_d.tcmd[c] = ENTRY_CMD[c][s_q.ent[c]];
              s_d.cst[c]  = C_WAIT;
            end
          end else begin
            // skip idle entries; give auto-poll a turn at wrap
            s_d.ent[c] = nxt(s_q.ent[c], LIST_LEN_CFG[c]);
            if (s_d.ent[c] == 7'h00) s_d.turn[c] = 1'b1;
          end
        end
        C_LQ: begin
          // long address known now; reissue with long form
          if (TX_DONE[c]) begin
            s_d.tcmd[c] = ENTRY_CMD[c][s_q.ent[c]];
            s_d.tl[c]   = 1'b1;
            s_d.cst[c]  = C_WAIT;
          end
        end
        C_WAIT: begin
          if (TX_DONE[c]) begin
            s_d.tv[c]  = 1'b0;
            s_d.tl[c]  = 1'b0;
            s_d.cst[c] = C_PICK;
            if (!s_q.ta[c]) begin
              if (ENTRY_CODE[c][s_q.ent[c]] == CODE_ONCE)
                s_d.en[c][s_q.ent[c]] = EN_OFF;
              s_d.ent[c]  = nxt(s_q.ent[c], LIST_LEN_CFG[c]);
              s_d.turn[c] = 1'b1;
            end
          end
        end
        default: s_d.cst[c] = C_PICK;
      endcase
    end

    // request decoder; its writes come last so a set wins
    case (s_q.rst)
      R_IDLE: begin
        if (LNK.blk[W_SEQ] != s_q.seen) begin
          s_d.seen = LNK.blk[W_SEQ];
          s_d.id   = LNK.blk[W_ID];
          s_d.ch   = LNK.blk[W_CHAN][0];
          s_d.k    = 6'h00;
          s_d.cnt  = (cw > MAX_CNT) ? MAX_CNT[5:0] : cw[5:0];
          if ((LNK.blk[W_ID] == ID_ENABLE ||
               LNK.blk[W_ID] == ID_DISABLE) &&
              LNK.blk[W_CHAN] < NCH_W && cw != EN_OFF) begin
            s_d.rst = R_WALK;
          end else if (LNK.blk[W_ID] == ID_WARM ||
                       LNK.blk[W_ID] == ID_COLD) begin
            s_d.clr = 1'b1;
            s_d.rst = R_BOOT;
          end
          // any other identifier only latches the seen, id, channel and count words
        end
      end
      R_WALK: begin
        // one index word per cycle, bad indices are skipped
        if (wi[15:7] == 9'h000 && wi[6:0] < LIST_LEN_CFG[s_q.ch] &&
            wi[6:0] < LIST_LEN_W &&
            gated(ENTRY_CODE[s_q.ch][wi[6:0]])) begin
          if (s_q.id == ID_ENABLE)
            s_d.en[s_q.ch][wi[6:0]] = EN_ON;
          else
            s_d.en[s_q.ch][wi[6:0]] = EN_OFF;
        end
        s_d.k = s_q.k + 6'h01;
        if (s_q.k + 6'h01 >= s_q.cnt) s_d.rst = R_IDLE;
      end
      R_BOOT: begin
        // block is zero from this edge; warm keeps enable words
        s_d      = '0;
        s_d.en   = (s_q.id == ID_WARM) ? s_q.en : '0;
        s_d.warm = (s_q.id == ID_WARM);
        s_d.cold = (s_q.id != ID_WARM);
      end
      default: s_d.rst = R_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) s_q <= '0;
    else s_q <= s_d;
  end

  // outputs straight from state flops
  assign LNK.blk_clr   = s_q.clr;
  assign TX_VALID      = s_q.tv;
  assign TX_ADDR       = s_q.tadr;
  assign TX_CMD        = s_q.tcmd;
  assign TX_ENTRY      = s_q.ent;
  assign TX_LONG       = s_q.tl;
  assign TX_CONST      = s_q.tc;
  assign TX_AUTO       = s_q.ta;
  assign TX_FAST       = s_q.tf;
  assign EN_WORDS      = s_q.en;
  assign RESTART_WARM  = s_q.warm;
  assign RESTART_COLD  = s_q.cold;
endmodule : hcl_dev

// ==== hw/hcl_host.sv ====
// controller end: AXI4-Lite registers that build request blocks
`timescale 1ns/1ps
module hcl_host (
  input  logic              CLK,
  input  logic              RST_B,
  hcl_if.host               LNK,
  input  logic [7:0]        S_AXI_AWADDR,
  input  logic              S_AXI_AWVALID,
  output logic              S_AXI_AWREADY,
  input  logic [31:0]       S_AXI_WDATA,
  input  logic [3:0]        S_AXI_WSTRB,
  input  logic              S_AXI_WVALID,
  output logic              S_AXI_WREADY,
  output logic [1:0]        S_AXI_BRESP,
  output logic              S_AXI_BVALID,
  input  logic              S_AXI_BREADY,
  input  logic [7:0]        S_AXI_ARADDR,
  input  logic              S_AXI_ARVALID,
  output logic              S_AXI_ARREADY,
  output logic [31:0]       S_AXI_RDATA,
  output logic [1:0]        S_AXI_RRESP,
  output logic              S_AXI_RVALID,
  input  logic              S_AXI_RREADY
);
  import hcl_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    hcl_blk_t     blk;
    logic [7:0]   awa;
    logic         aw_ok;
    logic [15:0]  wd;
    logic [1:0]   ws;
    logic         w_ok;
    logic         awr;
    logic         wr;
    logic         bv;
    logic [1:0]   br;
    logic         arr;
    logic         rv;
    logic [1:0]   rr;
    logic [31:0]  rd;
  } hcl_hst_t;

  hcl_hst_t  s_q;
  hcl_hst_t  s_d;
  hcl_word_t mw;
  logic [5:0] wsel;

  // ==========================================================
  // decoders
  function automatic logic [5:0] widx(input logic [7:0] a);
    // list window maps onto block words 4 to 63
    if (a >= REG_LIST) widx = a[7:2];
    else if (a[7:2] == REG_CHAN[7:2]) widx = W_CHAN;
    else if (a[7:2] == REG_CNT[7:2]) widx = W_CNT;
    else widx = W_ID;
  endfunction : widx

  function automatic logic is_stat(input logic [7:0] a);
    is_stat = (a[7:2] == REG_STAT[7:2]);
  endfunction : is_stat

  // byte-lane merge of the pending write into the old word
  assign wsel = widx(s_q.awa);
  assign mw   = {s_q.ws[1] ? s_q.wd[15:8] : s_q.blk[wsel][15:8],
                 s_q.ws[0] ? s_q.wd[7:0]  : s_q.blk[wsel][7:0]};

  // ==========================================================
  // next-state logic
  always_comb begin
    s_d = s_q;
    // handler's restart request zeroes the whole block
    if (LNK.blk_clr) s_d.blk = '0;
    if (s_q.bv && S_AXI_BREADY) s_d.bv = 1'b0;
    if (s_q.rv && S_AXI_RREADY) s_d.rv = 1'b0;
    if (S_AXI_AWVALID && s_q.awr) begin
      s_d.awa   = S_AXI_AWADDR;
      s_d.aw_ok = 1'b1;
    end
    if (S_AXI_WVALID && s_q.wr) begin
      s_d.wd   = S_AXI_WDATA[15:0];
      s_d.ws   = S_AXI_WSTRB[1:0];
      s_d.w_ok = 1'b1;
    end
    // address and data both held: perform the write
    if (s_q.aw_ok && s_q.w_ok && !s_q.bv) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok  = 1'b0;
      s_d.bv    = 1'b1;
      s_d.br    = RESP_OKAY;
      if (is_stat(s_q.awa)) begin
        s_d.br = RESP_SLV;
      end else if (wsel == W_CNT && (mw < MIN_CNT || mw > MAX_CNT)) begin
        s_d.br = RESP_SLV;
      end else begin
        s_d.blk[wsel] = mw;
        // new identifier goes out with a bumped sequence word
        if (wsel == W_ID)
          s_d.blk[W_SEQ] = s_q.blk[W_SEQ] + 16'h0001;
      end
    end
    // reads: status word packs id and sequence
    if (S_AXI_ARVALID && s_q.arr) begin
      s_d.rv = 1'b1;
      s_d.rr = RESP_OKAY;
      if (is_stat(S_AXI_ARADDR))
        s_d.rd = {s_q.blk[W_ID], s_q.blk[W_SEQ]};
      else
        s_d.rd = {16'h0000, s_q.blk[widx(S_AXI_ARADDR)]};
    end
    s_d.awr = !s_d.aw_ok && !s_d.bv;
    s_d.wr  = !s_d.w_ok && !s_d.bv;
    s_d.arr = !s_d.rv;
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) s_q <= '0;
    else s_q <= s_d;
  end

  // outputs straight from state flops
  assign LNK.blk       = s_q.blk;
  assign S_AXI_AWREADY = s_q.awr;
  assign S_AXI_WREADY  = s_q.wr;
  assign S_AXI_BVALID  = s_q.bv;
  assign S_AXI_BRESP   = s_q.br;
  assign S_AXI_ARREADY = s_q.arr;
  assign S_AXI_RVALID  = s_q.rv;
  assign S_AXI_RRESP   = s_q.rr;
  assign S_AXI_RDATA   = s_q.rd;
endmodule : hcl_host

// ==== tb/hcl_checker.sv ====
// assertions on the request link and channel outputs of the handler
`timescale 1ns/1ps
module hcl_checker (
  input logic                     CLK,
  input logic                     RST_B,
  input hcl_pkg::hcl_blk_t        blk,
  input logic                     blk_clr,
  input hcl_pkg::hcl_poll_t [1:0] POLL_MODE,
  input logic [1:0]               SECOND_MASTER,
  input logic [1:0]               TX_DONE,
  input logic [1:0]               TX_VALID,
  input logic [1:0][3:0]          TX_ADDR,
  input logic [1:0]               TX_LONG,
  input logic [1:0]               TX_AUTO,
  input logic [1:0]               TX_FAST,
  input logic                     RESTART_WARM,
  input logic                     RESTART_COLD
);
  import hcl_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================================
  // helpers: last multi-drop address, cycles without polling
  logic [3:0] last_q, last_d;
  logic       have_q, have_d;
  logic [7:0] none_q, none_d;
  // a restart drops the address history
  always_comb begin
    last_d = last_q;
    have_d = have_q & ~blk_clr;
    none_d = (POLL_MODE[0] != POLL_NONE) ? 8'h00 :
             (none_q == 8'hff) ? none_q : none_q + 8'h01;
    if (TX_VALID[1] && TX_AUTO[1]) begin
      last_d = TX_ADDR[1];
      have_d = ~blk_clr;
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      last_q <= 4'h0;
      have_q <= 1'b0;
      none_q <= 8'h00;
    end else begin
      last_q <= last_d;
      have_q <= have_d;
      none_q <= none_d;
    end
  end
  // ==========================================================
  // restart steps
  sequence s_warm_go;   blk_clr && blk[W_ID] == ID_WARM; endsequence
  sequence s_cold_go;   blk_clr && blk[W_ID] == ID_COLD; endsequence
  sequence s_warm_done; RESTART_WARM && !RESTART_COLD && blk == '0; endsequence
  sequence s_cold_done; RESTART_COLD && !RESTART_WARM && blk == '0; endsequence
  // ==========================================================
  // assertions
  clr_cause_a: assert property (
    blk_clr |-> blk[W_ID] == ID_WARM || blk[W_ID] == ID_COLD)
    else $error("block clear without restart request");
  warm_restart_a: assert property (s_warm_go |=> s_warm_done)
    else $error("warm restart not carried out");
  cold_restart_a: assert property (s_cold_go |=> s_cold_done)
    else $error("cold restart not carried out");
  restart_cause_a: assert property (
    RESTART_WARM || RESTART_COLD |-> $past(blk_clr))
    else $error("restart pulse without block clear");
  tx_hold_a: assert property (!blk_clr |=>
    ($past(TX_VALID) & ~$past(TX_DONE) & ~TX_VALID) == 2'h0)
    else $error("request dropped before done");
  fast_timing_a: assert property (RST_B && !blk_clr |=>
    TX_FAST == ~$past(SECOND_MASTER))
    else $error("fast timing does not follow second master option");
  p2p_addr_a: assert property ($rose(TX_VALID[0]) && TX_AUTO[0] &&
    POLL_MODE[0] == POLL_P2P && $stable(POLL_MODE[0])
    |-> TX_ADDR[0] == ADDR_P2P)
    else $error("point-to-point poll to wrong address");
  multi_order_a: assert property ($rose(TX_VALID[1]) && TX_AUTO[1] &&
    have_q |-> TX_ADDR[1] ==
    ((last_q == ADDR_MD_HI) ? ADDR_MD_LO : last_q + 4'h1))
    else $error("multi-drop poll out of order");
  none_auto_a: assert property ($rose(TX_VALID[0]) &&
    none_q == 8'hff |-> !TX_AUTO[0])
    else $error("auto poll issued with polling off");
  long_order_a: assert property ($rose(TX_VALID[0]) |-> !TX_LONG[0])
    else $error("long address used before short query");
endmodule : hcl_checker

// ==== tb/tb_command_list_control_handler.sv ====
// self-checking bench: controller and handler joined by the request link
`timescale 1ns/1ps
module tb_command_list_control_handler;
  import hcl_pkg::*;
  // ==========================================================
  // design-facing signals
  logic                   CLK = 1'b0;
  logic                   RST_B = 1'b0;
  hcl_poll_t [1:0]        POLL_MODE;
  logic [1:0]             SECOND_MASTER = 2'h0;
  logic [1:0]             TX_DONE = 2'h0;
  logic [1:0]             TX_VALID, TX_LONG, TX_AUTO, TX_FAST, TX_CONST;
  logic [1:0][6:0]        LIST_LEN_CFG, TX_ENTRY;
  logic [1:0][98:0][2:0]  ENTRY_CODE;
  logic [1:0][98:0][3:0]  ENTRY_ADDR;
  logic [1:0][98:0][7:0]  ENTRY_CMD;
  logic [1:0][98:0]       ENTRY_LONG, ENTRY_CONST;
  logic [1:0][3:0]        TX_ADDR;
  logic [1:0][7:0]        TX_CMD;
  logic [1:0][98:0][15:0] EN_WORDS;
  logic                   RESTART_WARM, RESTART_COLD;
  logic [7:0]             S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0]            S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [1:0]             S_AXI_BRESP;
  logic [3:0]             S_AXI_WSTRB = 4'hf;
  logic                   S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic                   S_AXI_ARVALID = 1'b0, S_AXI_BREADY = 1'b1;
  logic                   S_AXI_RREADY = 1'b1;
  logic                   S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY;
  logic                   S_AXI_BVALID, S_AXI_RVALID;
  // bench state
  int                     n_fail = 0;
  int                     num_checks = 0;
  logic [31:0]            rnd = 32'h1378fb24;
  logic [1:0][2:0]        dly = '0;
  logic                   seen3 = 1'b0;
  logic [31:0]            q_b[$], q_r[$], q_x[$], q_e[$];
  logic [15:0]            lst [5] = '{16'h2, 16'h3, 16'h4, 16'hc, 16'h7};

  always #2 CLK = ~CLK;

  hcl_if lnk ();
  hcl_dev u_hcl_dev (.CLK, .RST_B, .LNK(lnk), .POLL_MODE, .SECOND_MASTER,
    .LIST_LEN_CFG, .ENTRY_CODE, .ENTRY_ADDR, .ENTRY_CMD, .ENTRY_LONG,
    .ENTRY_CONST, .TX_DONE, .TX_VALID, .TX_ADDR, .TX_CMD, .TX_ENTRY,
    .TX_LONG, .TX_CONST, .TX_AUTO, .TX_FAST, .EN_WORDS, .RESTART_WARM,
    .RESTART_COLD);
  hcl_host u_hcl_host (.CLK, .RST_B, .LNK(lnk), .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP(), .S_AXI_RVALID, .S_AXI_RREADY);
  hcl_checker u_hcl_checker (.CLK, .RST_B, .blk(lnk.blk),
    .blk_clr(lnk.blk_clr), .POLL_MODE, .SECOND_MASTER, .TX_DONE,
    .TX_VALID, .TX_ADDR, .TX_LONG, .TX_AUTO, .TX_FAST, .RESTART_WARM,
    .RESTART_COLD);

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr

  task automatic chk_bus(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bus

  task automatic chk_dev(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_dev

  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] r);
    q_b.push_back({30'h0, r});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {16'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_r.push_back(e);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
  endtask : rd

  task automatic exp_en(input logic c, input logic [6:0] i,
                        input logic [15:0] v);
    q_e.push_back({8'h00, c, i, v});
  endtask : exp_en

  // a full walk ends well inside the wait
  task automatic req(input logic [15:0] ch, n, w, id);
    wr(REG_CHAN, ch, RESP_OKAY);
    wr(REG_CNT, n, RESP_OKAY);
    wr(REG_LIST, w, RESP_OKAY);
    wr(REG_SEND, id, RESP_OKAY);
    repeat (70) @(posedge CLK);
  endtask : req

  // ==========================================================
  // link engine: ends each transaction after a random delay
  always @(posedge CLK) begin
    rnd <= lfsr(rnd);
    SECOND_MASTER <= rnd[9:8];
    if (TX_VALID[0] && !TX_AUTO[0] && TX_ENTRY[0] == 7'h03 &&
        TX_CMD[0] == ENTRY_CMD[0][3] && TX_CONST[0] == ENTRY_CONST[0][3])
      seen3 <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      if (TX_DONE[c] || !TX_VALID[c]) begin
        TX_DONE[c] <= 1'b0;
        dly[c] <= 3'h0;
      end else begin
        dly[c] <= dly[c] + 3'h1;
        TX_DONE[c] <= (dly[c] >= {1'b0, rnd[2*c+:2]});
      end
    end
  end

  // ==========================================================
  // monitor: oldest note against what appears
  always @(posedge CLK) begin : mon
    logic [31:0] e;
    if (S_AXI_BVALID && S_AXI_BREADY)
      chk_bus("write response", q_b.pop_front(), {30'h0, S_AXI_BRESP});
    if (S_AXI_RVALID && S_AXI_RREADY)
      chk_bus("read data", q_r.pop_front(), S_AXI_RDATA);
    if (RESTART_WARM || RESTART_COLD)
      chk_bus("restart kind", q_x.pop_front(), {30'h0, RESTART_WARM,
              RESTART_COLD});
    if (q_e.size() > 0) begin
      e = q_e.pop_front();
      chk_dev("enable word", e[15:0], EN_WORDS[e[23]][e[22:16]]);
    end
  end

  // ==========================================================
  // main sequence
  initial begin : main
    POLL_MODE = {POLL_MULTI, POLL_P2P};
    LIST_LEN_CFG = {7'h09, 7'h0a};
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 99; i++) begin
        rnd = lfsr(rnd);
        ENTRY_ADDR[c][i] = rnd[3:0];
        ENTRY_CMD[c][i] = rnd[11:4];
        ENTRY_CONST[c][i] = rnd[12];
        ENTRY_LONG[c][i] = 1'b0;
        ENTRY_CODE[c][i] = CODE_CONT;
      end
    end
    ENTRY_CODE[0][3] = CODE_ONCE;
    ENTRY_CODE[0][4] = CODE_OFF;
    ENTRY_CODE[0][8] = 3'h1;
    ENTRY_LONG[0][8] = 1'b1;
    ENTRY_CODE[1][1] = 3'h1;
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(REG_STAT, 32'h0);
    wr(REG_STAT, 16'h0001, RESP_SLV);
    wr(REG_CNT, 16'h0000, RESP_SLV);
    wr(REG_CNT, 16'h003d, RESP_SLV);
    wr(REG_CNT, MAX_CNT, RESP_OKAY);
    for (int i = 1; i < 5; i++)
      wr(REG_LIST + {i[5:0], 2'h0}, lst[i], RESP_OKAY);
    req(16'h0000, 16'h0004, lst[0], ID_ENABLE);
    rd(REG_STAT, {ID_ENABLE, 16'h0001});
    exp_en(1'h0, 7'h02, EN_ON);
    exp_en(1'h0, 7'h04, EN_OFF);
    exp_en(1'h0, 7'h07, EN_OFF);
    exp_en(1'h0, 7'h0c, EN_OFF);
    exp_en(1'h1, 7'h02, EN_OFF);
    for (int k = 0; k < 1000 && seen3 !== 1'b1; k++) @(posedge CLK);
    repeat (20) @(posedge CLK);
    chk_dev("one-shot run", 16'h0001, {15'h0, seen3});
    exp_en(1'h0, 7'h03, EN_OFF);
    // no channel two, then the second channel alone
    req(16'h0002, 16'h0001, 16'h0007, ID_ENABLE);
    exp_en(1'h0, 7'h07, EN_OFF);
    exp_en(1'h1, 7'h07, EN_OFF);
    req(16'h0001, 16'h0001, 16'h0007, ID_ENABLE);
    exp_en(1'h1, 7'h07, EN_ON);
    exp_en(1'h0, 7'h07, EN_OFF);
    req(16'h0000, 16'h0001, 16'h0007, 16'h26b0);
    exp_en(1'h0, 7'h07, EN_OFF);
    POLL_MODE[0] <= POLL_NONE;
    req(16'h0000, 16'h0001, 16'h0002, ID_DISABLE);
    exp_en(1'h0, 7'h02, EN_OFF);
    repeat (300) @(posedge CLK);
    q_x.push_back(32'h2);
    wr(REG_SEND, ID_WARM, RESP_OKAY);
    repeat (10) @(posedge CLK);
    rd(REG_STAT, 32'h0);
    exp_en(1'h1, 7'h07, EN_ON);
    q_x.push_back(32'h1);
    wr(REG_SEND, ID_COLD, RESP_OKAY);
    repeat (10) @(posedge CLK);
    rd(REG_STAT, 32'h0);
    exp_en(1'h1, 7'h07, EN_OFF);
    repeat (5) @(posedge CLK);
    close_out();
  end

  // hang guard: the run needs under two thousand cycles
  initial begin : watchdog
    #200000;
    n_fail++;
    close_out();
  end
endmodule : tb_command_list_control_handler
